// ### rtl/fault_reaction_pkg.sv
// Constants, register map and encodings for the safety fault reaction block
package fault_reaction_pkg;

   // ************************************************************
   // Register bus
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] GRP_SEL_OFF = 8'h04;
   localparam logic [7:0] GRP_DATA_OFF = 8'h08;
   localparam logic [7:0] ENABLES_OFF = 8'h0c;
   localparam logic [7:0] REPORT_OFF = 8'h10;
   localparam logic [7:0] GRP_OVER_OFF = 8'h14;
   localparam logic [7:0] MODEN_LO_OFF = 8'h18;
   localparam logic [7:0] MODEN_HI_OFF = 8'h1c;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_W = 2;
   localparam int CTRL_SHARED_BIT = 2;
   localparam int CTRL_ESTOP_BIT = 3;
   localparam int CTRL_RESTART_BIT = 4;
   localparam int ENABLES_RACK_LSB = 2;
   localparam int REPORT_CODE_LSB = 8;
   localparam int SLOT_W = 8;
   localparam int GROUP_ID_W = 4;
   localparam int NUM_GROUPS = 16;
   localparam int NUM_CU = 2;

   // ************************************************************
   // Limits and reset values
   // ************************************************************
   localparam logic [7:0] GROUP_MAX_MEMBERS = 8'h0a;
   localparam logic CTRL_SHARED_RESET = 1'b1;
   localparam logic CTRL_ESTOP_RESET = 1'b0;

   typedef enum logic [1:0] {
      PARAM_DISPLAY = 2'b00,
      PARAM_NORMAL = 2'b01,
      PARAM_EMERGENCY = 2'b10
   } fault_param_t;

   localparam fault_param_t CTRL_MODE_RESET = PARAM_NORMAL;

   typedef enum logic [2:0] {
      CODE_NONE = 3'b000,
      CODE_SINGLE = 3'b001,
      CODE_DOUBLE = 3'b010,
      CODE_RACK_BUS = 3'b011,
      CODE_INPUT = 3'b100,
      CODE_CENTRAL = 3'b101,
      CODE_SHUT_FAIL = 3'b110
   } fault_code_t;

endpackage : fault_reaction_pkg

// ### rtl/safety_shutdown_fault_reaction.sv
// Fault reaction logic: decides which safety enable signals are withdrawn on a fault
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R01) Single output fault: switch off that module; emergency-off leaves the module enable on and withdraws central unit instead
// (R02) Normal grouping: whole group off, ten max
// (R03) Emergency-off: output fault withdraws central unit
// (R04) Display-only bus/double fault: report, rack stays
// (R05) Normal: bus/double fault withdraws coupling enable
// (R06) Central unit or its bus faults: withdraw
// (R07) Faulty input module reads all zeros
// (R08) Emergency stop variable withdraws central units
// (R09) Display-only: integrated shutdown, else coupling enable
// (R10) Normal: escalate to central unit if needed
// (R11) Shared bus: withdraw both central units
// (R12) Separate buses: withdraw only owning unit
// (R13) Channel plus switch-off fault means double
// (R14) Configurer: display-only only up to SIL 1
// (R15) Withdrawn enables stay off until restart
module safety_shutdown_fault_reaction #(
   parameter int N_RACK = 4,
   parameter int SLOTS = 16,
   parameter int IN_W = 8
) (
   input wire logic ref_clk, // 20 MHz clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [7:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after reg_rd
   input wire logic [N_RACK*SLOTS-1:0] out_fault_in, // Output channel or supply fault
   input wire logic [N_RACK*SLOTS-1:0] out_switch_fault_in, // Switch-off section fault
   input wire logic [N_RACK*SLOTS-1:0] out_shutdown_fail_in, // Integrated shutdown failed
   input wire logic [N_RACK*SLOTS-1:0] in_fault_in, // Input module fault
   input wire logic [N_RACK*SLOTS*IN_W-1:0] in_raw, // Raw input module values
   input wire logic [N_RACK-1:0] rack_bus_fault_in, // I/O bus fault inside a subrack
   input wire logic [N_RACK-1:0] coupling_fail_in, // Coupling module cannot shut off
   input wire logic [1:0] central_unit_fault_in, // Central unit fault
   input wire logic [1:0] central_unit_bus_fault_in, // Bus fault unit to couplers
   output logic [1:0] central_unit_safety_enable_signal, // Central unit enables
   output logic [N_RACK-1:0] coupling_safety_enable_signal, // Subrack coupling enables
   output logic [N_RACK*SLOTS-1:0] module_safety_enable_signal, // Output module enables
   output logic [N_RACK*SLOTS*IN_W-1:0] in_value, // Inputs as seen by the program
   output logic report_strobe, // One-cycle pulse on a new fault
   output logic [7:0] report_slot, // Module, subrack or central unit number of the fault
   output logic [2:0] report_code // Fault code
);

   localparam int NUM_MOD = N_RACK * SLOTS;
   localparam int SYNC_W = 4 * NUM_MOD + NUM_MOD * IN_W + 2 * N_RACK + 4;

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (NUM_MOD > 64 || SLOTS < 1 || N_RACK > 16 || N_RACK < 2 || (N_RACK % 2) != 0) begin : g_bad
      $error("need 1 to 64 modules and an even 2 to 16 subracks");
   end

   function automatic int owner_of(input int rack);
      // With separate buses the lower half of subracks hangs off unit 0
      return (rack < N_RACK / 2) ? 0 : 1;
   endfunction : owner_of

   // ************************************************************
   // Input synchroniser
   // ************************************************************
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {out_fault_in, out_switch_fault_in, out_shutdown_fail_in, in_fault_in,
                       in_raw, rack_bus_fault_in, coupling_fail_in, central_unit_fault_in,
                       central_unit_bus_fault_in};
         sync2_reg <= sync1_reg;
      end
   end

   logic [NUM_MOD-1:0] ofault;
   logic [NUM_MOD-1:0] osw;
   logic [NUM_MOD-1:0] oshut;
   logic [NUM_MOD-1:0] ifault;
   logic [NUM_MOD*IN_W-1:0] iraw;
   logic [N_RACK-1:0] rbus;
   logic [N_RACK-1:0] cfail;
   logic [1:0] cfault;
   logic [1:0] cbus;

   assign {ofault, osw, oshut, ifault, iraw, rbus, cfail, cfault, cbus} = sync2_reg;

   // ************************************************************
   // Software registers
   // ************************************************************
   fault_reaction_pkg::fault_param_t mode_reg;
   logic shared_reg;
   logic estop_reg;
   logic restart;
   logic [5:0] grp_sel_reg;
   logic [fault_reaction_pkg::GROUP_ID_W-1:0] group_tbl [NUM_MOD];

   assign restart = reg_wr && reg_addr == fault_reaction_pkg::CTRL_OFF
                    && reg_wdata[fault_reaction_pkg::CTRL_RESTART_BIT];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= fault_reaction_pkg::CTRL_MODE_RESET;
         shared_reg <= fault_reaction_pkg::CTRL_SHARED_RESET;
         estop_reg <= fault_reaction_pkg::CTRL_ESTOP_RESET;
      end else if (reg_wr && reg_addr == fault_reaction_pkg::CTRL_OFF) begin
         // An undefined mode code falls back to the strictest reaction
         unique case (reg_wdata[fault_reaction_pkg::CTRL_MODE_LSB +:
                                fault_reaction_pkg::CTRL_MODE_W])
            2'h0: mode_reg <= fault_reaction_pkg::PARAM_DISPLAY;
            2'h1: mode_reg <= fault_reaction_pkg::PARAM_NORMAL;
            default: mode_reg <= fault_reaction_pkg::PARAM_EMERGENCY;
         endcase
         shared_reg <= reg_wdata[fault_reaction_pkg::CTRL_SHARED_BIT];
         estop_reg <= reg_wdata[fault_reaction_pkg::CTRL_ESTOP_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         grp_sel_reg <= '0;
         for (int m = 0; m < NUM_MOD; m++) begin
            group_tbl[m] <= '0;
         end
      end else if (reg_wr && reg_addr == fault_reaction_pkg::GRP_SEL_OFF) begin
         grp_sel_reg <= reg_wdata[5:0];
      end else if (reg_wr && reg_addr == fault_reaction_pkg::GRP_DATA_OFF
                   && 32'(grp_sel_reg) < NUM_MOD) begin
         group_tbl[grp_sel_reg] <= reg_wdata[fault_reaction_pkg::GROUP_ID_W-1:0];
      end
   end

   // ************************************************************
   // Fault classification and reaction
   // ************************************************************
   logic [NUM_MOD-1:0] dbl;
   logic [NUM_MOD-1:0] single;
   logic [7:0] grp_count [fault_reaction_pkg::NUM_GROUPS];
   logic [fault_reaction_pkg::NUM_GROUPS-1:0] grp_hit;
   logic [fault_reaction_pkg::NUM_GROUPS-1:0] grp_over;
   logic [NUM_MOD-1:0] mod_kill;
   logic [N_RACK-1:0] rack_kill;
   logic [1:0] cu_req;
   logic [1:0] cu_kill;

   assign dbl = ofault & osw; // see (R13)
   assign single = ofault & ~osw;

   always_comb begin
      grp_hit = '0;
      for (int g = 0; g < fault_reaction_pkg::NUM_GROUPS; g++) begin
         grp_count[g] = '0;
      end
      for (int m = 0; m < NUM_MOD; m++) begin
         if (group_tbl[m] != '0) begin
            grp_count[group_tbl[m]] = grp_count[group_tbl[m]] + 8'h01;
            if (single[m]) begin
               grp_hit[group_tbl[m]] = 1'b1;
            end
         end
      end
      // An over-full group is not honoured; software sees it in the over mask
      for (int g = 0; g < fault_reaction_pkg::NUM_GROUPS; g++) begin
         grp_over[g] = grp_count[g] > fault_reaction_pkg::GROUP_MAX_MEMBERS; // see (R02)
      end
   end

   always_comb begin
      mod_kill = '0;
      rack_kill = '0;
      cu_req = '0;
      for (int m = 0; m < NUM_MOD; m++) begin
         if (ofault[m] && mode_reg != fault_reaction_pkg::PARAM_EMERGENCY) begin
            mod_kill[m] = 1'b1; // see (R01)
         end
         if (mode_reg == fault_reaction_pkg::PARAM_NORMAL && group_tbl[m] != '0
             && grp_hit[group_tbl[m]] && !grp_over[group_tbl[m]]) begin
            mod_kill[m] = 1'b1; // see (R02)
         end
         // Integrated shutdown failed: fall back to the coupling module
         if (oshut[m]) begin
            rack_kill[m / SLOTS] = 1'b1; // see (R09)
         end
         if (dbl[m] && mode_reg == fault_reaction_pkg::PARAM_NORMAL) begin
            rack_kill[m / SLOTS] = 1'b1; // see (R05)
         end
         if (ofault[m] && mode_reg == fault_reaction_pkg::PARAM_EMERGENCY) begin
            cu_req[owner_of(m / SLOTS)] = 1'b1; // see (R03)
         end
      end
      for (int r = 0; r < N_RACK; r++) begin
         // Display-only leaves the coupling enable on for bus faults
         if (rbus[r] && mode_reg == fault_reaction_pkg::PARAM_NORMAL) begin
            rack_kill[r] = 1'b1; // see (R05) (R04)
         end
         if (rbus[r] && mode_reg == fault_reaction_pkg::PARAM_EMERGENCY) begin
            cu_req[owner_of(r)] = 1'b1; // see (R03)
         end
         if (cfail[r] && mode_reg == fault_reaction_pkg::PARAM_NORMAL) begin
            cu_req[owner_of(r)] = 1'b1; // see (R10)
         end
      end
      for (int c = 0; c < fault_reaction_pkg::NUM_CU; c++) begin
         if (cfault[c] || cbus[c] || estop_reg) begin
            cu_req[c] = 1'b1; // see (R06) (R08)
         end
      end
      if (shared_reg) begin
         cu_kill = {2{|cu_req}}; // see (R11)
      end else begin
         cu_kill = cu_req; // see (R12)
      end
   end

   // ************************************************************
   // Latched enables; a kill in the restart cycle still wins
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         central_unit_safety_enable_signal <= '1;
         coupling_safety_enable_signal <= '1;
         module_safety_enable_signal <= '1;
      end else begin
         central_unit_safety_enable_signal <= (central_unit_safety_enable_signal
                                               | {2{restart}}) & ~cu_kill; // see (R15)
         coupling_safety_enable_signal <= (coupling_safety_enable_signal
                                           | {N_RACK{restart}}) & ~rack_kill; // see (R15)
         module_safety_enable_signal <= (module_safety_enable_signal
                                         | {NUM_MOD{restart}}) & ~mod_kill; // see (R15)
      end
   end

   // ************************************************************
   // Input forcing
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_value <= '0;
      end else begin
         for (int m = 0; m < NUM_MOD; m++) begin
            in_value[m*IN_W +: IN_W] <= ifault[m] ? '0 : iraw[m*IN_W +: IN_W]; // see (R07)
         end
      end
   end

   // ************************************************************
   // Fault report: a module event beats a subrack event, which beats a unit event; lowest index wins within each
   // ************************************************************
   logic [NUM_MOD-1:0] ofault_prev_reg;
   logic [NUM_MOD-1:0] dbl_prev_reg;
   logic [NUM_MOD-1:0] oshut_prev_reg;
   logic [NUM_MOD-1:0] ifault_prev_reg;
   logic [N_RACK-1:0] rbus_prev_reg;
   logic [1:0] cu_prev_reg;
   logic rep_hit;
   logic [7:0] rep_slot;
   fault_reaction_pkg::fault_code_t rep_code;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {ofault_prev_reg, dbl_prev_reg, oshut_prev_reg, ifault_prev_reg, rbus_prev_reg,
          cu_prev_reg} <= '0;
      end else begin
         {ofault_prev_reg, dbl_prev_reg, oshut_prev_reg, ifault_prev_reg, rbus_prev_reg,
          cu_prev_reg} <= {ofault, dbl, oshut, ifault, rbus, cfault | cbus};
      end
   end

   always_comb begin
      rep_hit = 1'b0;
      rep_slot = '0;
      rep_code = fault_reaction_pkg::CODE_NONE;
      for (int c = fault_reaction_pkg::NUM_CU - 1; c >= 0; c--) begin
         if ((cfault[c] || cbus[c]) && !cu_prev_reg[c]) begin
            rep_hit = 1'b1;
            rep_slot = 8'(c);
            rep_code = fault_reaction_pkg::CODE_CENTRAL;
         end
      end
      for (int r = N_RACK - 1; r >= 0; r--) begin
         if (rbus[r] && !rbus_prev_reg[r]) begin
            rep_hit = 1'b1;
            rep_slot = 8'(r);
            rep_code = fault_reaction_pkg::CODE_RACK_BUS; // see (R04)
         end
      end
      for (int m = NUM_MOD - 1; m >= 0; m--) begin
         if (ifault[m] && !ifault_prev_reg[m]) begin
            rep_hit = 1'b1;
            rep_slot = 8'(m);
            rep_code = fault_reaction_pkg::CODE_INPUT;
         end
         if (ofault[m] && !ofault_prev_reg[m]) begin
            rep_hit = 1'b1;
            rep_slot = 8'(m);
            rep_code = fault_reaction_pkg::CODE_SINGLE;
         end
         if (oshut[m] && !oshut_prev_reg[m]) begin
            rep_hit = 1'b1;
            rep_slot = 8'(m);
            rep_code = fault_reaction_pkg::CODE_SHUT_FAIL;
         end
         if (dbl[m] && !dbl_prev_reg[m]) begin
            rep_hit = 1'b1;
            rep_slot = 8'(m);
            rep_code = fault_reaction_pkg::CODE_DOUBLE; // see (R04) (R13)
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         report_strobe <= 1'b0;
         report_slot <= '0;
         report_code <= fault_reaction_pkg::CODE_NONE;
      end else begin
         report_strobe <= rep_hit;
         if (rep_hit) begin
            report_slot <= rep_slot;
            report_code <= rep_code;
         end
      end
   end

   // ************************************************************
   // Register read port
   // ************************************************************
   logic [63:0] mod_en64;

   assign mod_en64 = 64'(module_safety_enable_signal);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            fault_reaction_pkg::CTRL_OFF: reg_rdata <= {28'h0, estop_reg, shared_reg, mode_reg};
            fault_reaction_pkg::GRP_SEL_OFF: reg_rdata <= {26'h0, grp_sel_reg};
            fault_reaction_pkg::GRP_DATA_OFF:
               reg_rdata <= (32'(grp_sel_reg) < NUM_MOD) ? 32'(group_tbl[grp_sel_reg]) : 32'h0;
            fault_reaction_pkg::ENABLES_OFF:
               reg_rdata <= 32'({coupling_safety_enable_signal,
                                 central_unit_safety_enable_signal});
            fault_reaction_pkg::REPORT_OFF: reg_rdata <= {21'h0, report_code, report_slot};
            fault_reaction_pkg::GRP_OVER_OFF: reg_rdata <= {16'h0, grp_over};
            fault_reaction_pkg::MODEN_LO_OFF: reg_rdata <= mod_en64[31:0];
            fault_reaction_pkg::MODEN_HI_OFF: reg_rdata <= mod_en64[63:32];
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : safety_shutdown_fault_reaction

`default_nettype wire

// ### verification/io_field_model.sv
// Far-side model: output, input and coupling modules on the I/O bus
`timescale 1ns/1ps
`default_nettype none
module io_field_model #(
   parameter int N = 64,
   parameter int W = 8
) (
   input wire logic [2:0] kind, // Fault kind to present
   input wire logic on, // Fault present
   output logic [N-1:0] of, // Output channel fault
   output logic [N-1:0] sf, // Switch-off section fault
   output logic [N-1:0] fl, // Integrated shutdown failed
   output logic [N-1:0] inf, // Input module fault
   output logic [N*W-1:0] raw, // Raw input values
   output logic [3:0] rb, // Subrack bus fault
   output logic [3:0] cpf, // Coupling cannot shut off
   output logic [1:0] cuf, // Central unit fault
   output logic [1:0] cbf // Central unit bus fault
);
   // ****************************************
   // Fault sources: module 5 and module 0 of subrack 0, subrack 0 itself and the central units
   // ****************************************
   always_comb begin
      {of, sf, fl, inf, rb, cpf, cuf, cbf} = '0;
      raw = {N{8'ha5}};
      if (on) begin
         case (kind)
            3'h0: of[5] = 1'b1;
            3'h1: {of[5], sf[5]} = 2'h3;
            3'h2: rb[0] = 1'b1;
            3'h3: {of[5], fl[5]} = 2'h3;
            3'h4: cuf[0] = 1'b1;
            3'h5: {rb[0], cpf[0]} = 2'h3;
            3'h6: inf[0] = 1'b1;
            default: cbf[1] = 1'b1;
         endcase
      end
   end
endmodule : io_field_model
`default_nettype wire

// ### verification/safety_shutdown_fault_reaction_assertions.sv
// Port-level checker for the safety fault reaction block
`timescale 1ns/1ps
`default_nettype none
module fault_reaction_checker #(
   parameter int N_RACK = 4,
   parameter int SLOTS = 16,
   parameter int IN_W = 8
) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic reg_wr, // Write strobe
   input wire logic [N_RACK*SLOTS-1:0] out_fault_in, // Channel fault
   input wire logic [N_RACK*SLOTS-1:0] out_switch_fault_in, // Switch-off fault
   input wire logic [N_RACK*SLOTS-1:0] out_shutdown_fail_in, // Shutdown failed
   input wire logic [N_RACK*SLOTS-1:0] in_fault_in, // Input fault
   input wire logic [1:0] central_unit_fault_in, // Unit fault
   input wire logic [1:0] central_unit_bus_fault_in, // Unit bus fault
   input wire logic [1:0] central_unit_safety_enable_signal, // Unit enables
   input wire logic [N_RACK-1:0] coupling_safety_enable_signal, // Subrack enables
   input wire logic [N_RACK*SLOTS-1:0] module_safety_enable_signal, // Module enables
   input wire logic [N_RACK*SLOTS*IN_W-1:0] in_value, // Program inputs
   input wire logic report_strobe, // New fault pulse
   input wire logic [2:0] report_code // Fault code
);
   logic [N_RACK*SLOTS-1:0] dbl;
   assign dbl = out_fault_in & out_switch_fault_in;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ****************************************
   // Fault reactions
   // ****************************************
   // Two sync flops plus a decision flop, so three samples are enough
   sequence held3(s);
      s [*3];
   endsequence
   central_off_a: assert property (
      held3(central_unit_fault_in[0]) |=> !central_unit_safety_enable_signal[0])
      else $error("unit 0 enable kept on unit fault");
   unit_bus_a: assert property (
      held3(central_unit_bus_fault_in[1]) |=> !central_unit_safety_enable_signal[1])
      else $error("unit 1 enable kept on unit bus fault");
   single_off_a: assert property (
      held3(out_fault_in[5]) |=> (!module_safety_enable_signal[5]
      || !(&central_unit_safety_enable_signal)))
      else $error("module 5 still enabled on its fault");
   shut_fail_a: assert property (
      held3(|out_shutdown_fail_in[SLOTS-1:0]) |=> !coupling_safety_enable_signal[0])
      else $error("subrack 0 kept on after shutdown failure");
   input_zero_a: assert property (
      in_fault_in[0] [*4] |=> in_value[IN_W-1:0] == '0)
      else $error("faulty input module not read as zero");
   double_code_a: assert property (
      report_strobe && report_code == fault_reaction_pkg::CODE_DOUBLE |-> $past(dbl, 3) != '0)
      else $error("double reported without both faults");
   // A withdrawn enable may only come back the cycle after a register write
   rearm_unit_a: assert property (
      (|(central_unit_safety_enable_signal & ~$past(central_unit_safety_enable_signal)))
      |-> $past(reg_wr))
      else $error("unit enable returned without restart");
   rearm_rack_a: assert property (
      (|(coupling_safety_enable_signal & ~$past(coupling_safety_enable_signal)))
      |-> $past(reg_wr))
      else $error("subrack enable returned without restart");
   rearm_mod_a: assert property (
      (|(module_safety_enable_signal & ~$past(module_safety_enable_signal)))
      |-> $past(reg_wr))
      else $error("module enable returned without restart");
endmodule : fault_reaction_checker
`default_nettype wire

// ### verification/safety_shutdown_fault_reaction_tb.sv
// Self-checking testbench for the safety fault reaction block
`timescale 1ns/1ps
`default_nettype none
module safety_shutdown_fault_reaction_tb;
   typedef struct packed {
      logic [1:0] md; logic [2:0] k; logic [1:0] cu; logic rk; logic mo;
      logic cr; logic cm; logic [2:0] code;
   } row_t;
   logic ref_clk, rst, reg_wr, reg_rd, on, rs;
   logic [7:0] reg_addr, rslot;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [2:0] kind, rcode;
   logic [63:0] of, sf, fl, inf, mod;
   logic [511:0] raw, in_value;
   logic [3:0] rb, cpf, rk;
   logic [1:0] cuf, cbf, cu;
   int fails, n_checks;
   // Mode, kind, units, subrack 0, module 5, compare flags, report code
   row_t rows [15] = '{
      '{2'h0, 3'h0, 2'h3, 1'h1, 1'h0, 1'h1, 1'h1, 3'h1},
      '{2'h1, 3'h0, 2'h3, 1'h1, 1'h0, 1'h1, 1'h1, 3'h1},
      '{2'h2, 3'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1},
      '{2'h0, 3'h1, 2'h3, 1'h1, 1'h0, 1'h1, 1'h1, 3'h2},
      '{2'h1, 3'h1, 2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 3'h2},
      '{2'h2, 3'h1, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h2},
      '{2'h0, 3'h2, 2'h3, 1'h1, 1'h1, 1'h1, 1'h1, 3'h3},
      '{2'h1, 3'h2, 2'h3, 1'h0, 1'h0, 1'h1, 1'h0, 3'h3},
      '{2'h2, 3'h2, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h3},
      '{2'h0, 3'h3, 2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 3'h6},
      '{2'h1, 3'h3, 2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 3'h6},
      '{2'h1, 3'h5, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h3},
      '{2'h0, 3'h4, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h5},
      '{2'h1, 3'h7, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h5},
      '{2'h0, 3'h6, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0}
   };
   safety_shutdown_fault_reaction dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .out_fault_in(of), .out_switch_fault_in(sf), .out_shutdown_fail_in(fl),
      .in_fault_in(inf), .in_raw(raw), .rack_bus_fault_in(rb), .coupling_fail_in(cpf),
      .central_unit_fault_in(cuf), .central_unit_bus_fault_in(cbf),
      .central_unit_safety_enable_signal(cu), .coupling_safety_enable_signal(rk),
      .module_safety_enable_signal(mod), .in_value(in_value), .report_strobe(rs),
      .report_slot(rslot), .report_code(rcode));
   io_field_model far (.kind(kind), .on(on), .of(of), .sf(sf), .fl(fl), .inf(inf),
      .raw(raw), .rb(rb), .cpf(cpf), .cuf(cuf), .cbf(cbf));
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      #500us;
      fails++;
      close_out;
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {rst, reg_wr, reg_rd, on, reg_addr, reg_wdata, kind, fails, n_checks} = '0;
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 15; i++) begin
         on <= 1'b0;
         cyc(4);
         wr(fault_reaction_pkg::CTRL_OFF, 32'h14 | rows[i].md);
         cyc(4);
         check("rearm", {cu, rk, &mod}, 7'h7f);
         // Last row raises the emergency stop beside a harmless input fault
         wr(fault_reaction_pkg::CTRL_OFF, {28'h0, rows[i].code == 3'h0, 1'b1, rows[i].md});
         kind <= rows[i].k;
         on <= 1'b1;
         cyc(5);
         check("units", cu, rows[i].cu);
         if (rows[i].cr) check("rack0", rk[0], rows[i].rk);
         if (rows[i].cm) check("mod5", mod[5], rows[i].mo);
         if (rows[i].code != 3'h0) check("code", rcode, rows[i].code);
         if (rows[i].code != 3'h0) check("slot", rslot,
            rows[i].k inside {3'h0, 3'h1, 3'h3} ? 8'h5 : 8'(rows[i].k == 3'h7));
         on <= 1'b0;
         wr(fault_reaction_pkg::CTRL_OFF, {30'h1, rows[i].md});
         cyc(5);
         check("hold", cu, rows[i].cu);
      end
      @(posedge ref_clk);
      rst <= 1'b1;
      cyc(2);
      check("reset en", {cu, rk, &mod}, 7'h7f);
      rst <= 1'b0;
      rd(fault_reaction_pkg::CTRL_OFF, d);
      check("ctrl", d, 32'h5);
      wr(fault_reaction_pkg::ENABLES_OFF, 32'h0);
      rd(fault_reaction_pkg::ENABLES_OFF, d);
      check("enables", d, 32'h3f);
      rd(8'hfc, d);
      check("unmapped", d, 32'h0);
      wr(fault_reaction_pkg::GRP_SEL_OFF, 32'h5);
      wr(fault_reaction_pkg::GRP_DATA_OFF, 32'h1);
      wr(fault_reaction_pkg::GRP_SEL_OFF, 32'h6);
      wr(fault_reaction_pkg::GRP_DATA_OFF, 32'h1);
      kind <= 3'h0;
      on <= 1'b1;
      cyc(5);
      rd(fault_reaction_pkg::MODEN_LO_OFF, d);
      check("group", d, 32'hffffff9f);
      check("group rack", rk, 4'hf);
      on <= 1'b0;
      cyc(4);
      wr(fault_reaction_pkg::CTRL_OFF, 32'h11);
      cyc(4);
      kind <= 3'h4;
      on <= 1'b1;
      cyc(5);
      check("own unit", cu, 2'h2);
      on <= 1'b0;
      cyc(4);
      wr(fault_reaction_pkg::CTRL_OFF, 32'h15);
      cyc(4);
      kind <= 3'h6;
      on <= 1'b1;
      cyc(3);
      check("strobe", rs, 1'b1);
      cyc(2);
      check("strobe end", rs, 1'b0);
      check("zero in", in_value[15:0], 16'ha500);
      check("in enables", {cu, rk, &mod}, 7'h7f);
      rd(fault_reaction_pkg::REPORT_OFF, d);
      check("report", d, 32'h400);
      close_out;
   end
endmodule : safety_shutdown_fault_reaction_tb
bind safety_shutdown_fault_reaction fault_reaction_checker #(.N_RACK(N_RACK), .SLOTS(SLOTS),
   .IN_W(IN_W)) chk (.*);
`default_nettype wire
